// ### hw/rio_top.sv
/*
 * rio_top: interrupt routing of an rtc onto two open-drain,
 * active-low outputs, with an apb register slave.
 * assumes: source flags and counter increments arrive synchronous to
 * pclk; an external pull-up on each output pin.
 */
// Local design decision: the APB slave port.
// Summary of operation
// RQ1: minute increments set the tick flag only while the second enable is off
// RQ2: tick flag set on enabled counter increment
// RQ3: pulse mode gives one pulse per tick (a tick while the tick flag is still set starts no pulse)
// RQ4: level mode holds until flag cleared
// RQ5: pulse lasts one 64 Hz period
// RQ6: clearing tick flag ends pulse at once
// RQ7: watchdog level follows flag, never pulsed
// RQ8: watchdog releases when flag returns zero
// RQ9: alarm level follows alarm flag
// RQ10: each stamp enable gates its flag
// RQ11: switchover level follows switchover flag
// RQ12: low battery follows flag and enable
// RQ13: low battery flag is read only
// RQ14: software write clears the tick flag
// RQ15: masks 31h/32h for a, 33h/34h for b
// RQ16: mask one blocks; masks reset to one (with both ticks on, a clear minute mask still passes second ticks)
// RQ17: low mask bit layout for six sources
// RQ18: high mask bits hold four stamps
// RQ19: unused mask bits read zero
// RQ20: outputs open-drain, released when all disabled
// RQ21: pulse mode only for tick source
// RQ22: output low when any unmasked request
// RQ23: host pulls up and clears flags
`timescale 1ns/1ps

module rio_top
    import rio_pkg::*;
#(
    parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // source events and flags
    input  wire rio_pkg::rio_count_t counts,
    input  wire rio_pkg::rio_flags_t flags,
    // open-drain outputs
    output logic                     irq_out_a_o,
    output logic                     irq_out_a_oe,
    output logic                     irq_out_b_o,
    output logic                     irq_out_b_oe
);
    import rio_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [5:0]              mask_a_lo_r;
    logic [3:0]              mask_a_hi_r;
    logic [5:0]              mask_b_lo_r;
    logic [3:0]              mask_b_hi_r;
    logic [11:0]             ctrl_r;
    logic                    tick_flag_r;
    logic                    tick_flag_nxt;
    rio_pulse_t              pulse_state_r;
    logic [PULSE_CNT_W-1:0]  pulse_cnt_r;
    logic                    pready_r;
    logic [31:0]             prdata_r;
    logic                    pslverr_r;
    logic                    irq_a_oe_r;
    logic                    irq_b_oe_r;
    logic                    irq_a_o_r;
    logic                    irq_b_o_r;

    logic                    wr_en;
    logic                    setup;
    logic [7:0]              idx;
    logic                    tick_set;
    logic                    tick_clr;
    logic                    tick_req;
    logic                    req_a;
    logic                    req_b;

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_r & pwrite;
    assign idx   = paddr[9:2];

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] i,
                                    input logic [1:0] low_bits);
        begin
            mapped = (low_bits == 2'h0) &&
                     (i == IDX_MASK_A_LO || i == IDX_MASK_A_HI ||
                      i == IDX_MASK_B_LO || i == IDX_MASK_B_HI ||
                      i == IDX_CTRL || i == IDX_FLAGS);
        end
    endfunction

    // combined request of one output from its two masks
    function automatic logic route(input logic [5:0] mlo,
                                   input logic [3:0] mhi,
                                   input logic [11:0] ctl,
                                   input logic tick,
                                   input rio_flags_t f);
        logic tick_ok;
        logic lvl;
        begin
            tick_ok = 1'b0;
            lvl     = 1'b0;
            // the tick flag reaches the pin while either enabled tick source has its mask clear
            tick_ok = (ctl[CTL_LONG] & ~mlo[MLO_LONG]) |
                      (ctl[CTL_SHORT] & ~mlo[MLO_SHORT]);  // [RQ1] [RQ16] [RQ17]
            lvl = (ctl[CTL_WDOG] & f.watchdog_flag & ~mlo[MLO_WDOG])        // [RQ7] [RQ8]
                | (ctl[CTL_ALARM] & f.alarm_flag & ~mlo[MLO_ALARM])         // [RQ9]
                | (|(ctl[CTL_STAMP+:4] & f.stamp_flags & ~mhi))             // [RQ10] [RQ18]
                | (ctl[CTL_SWITCH] & f.switchover_flag & ~mlo[MLO_SWITCH])  // [RQ11]
                | (ctl[CTL_LOWBAT] & f.low_battery_flag & ~mlo[MLO_LOWBAT]); // [RQ12]
            route = (tick & tick_ok) | lvl;  // [RQ22] [RQ21]
        end
    endfunction

    // ------------------------------------------------------------
    // mask registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_a_lo_r <= MASK_LO_RST;  // [RQ16]
            mask_a_hi_r <= MASK_HI_RST;
            mask_b_lo_r <= MASK_LO_RST;
            mask_b_hi_r <= MASK_HI_RST;
        end
        else if (wr_en && paddr[1:0] == 2'h0)
        begin
            case (idx)
                IDX_MASK_A_LO: mask_a_lo_r <= pwdata[5:0];  // [RQ15]
                IDX_MASK_A_HI: mask_a_hi_r <= pwdata[3:0];
                IDX_MASK_B_LO: mask_b_lo_r <= pwdata[5:0];
                IDX_MASK_B_HI: mask_b_hi_r <= pwdata[3:0];
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= CTRL_RST;
        end
        else if (wr_en && paddr[1:0] == 2'h0 && idx == IDX_CTRL)
        begin
            ctrl_r <= pwdata[11:0];
        end
    end

    // ------------------------------------------------------------
    // tick flag: set wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_comb
    begin
        // minute counter only when the second tick is off
        if (ctrl_r[CTL_SHORT])
        begin
            tick_set = counts.second_inc;  // [RQ2]
        end
        else if (ctrl_r[CTL_LONG])
        begin
            tick_set = counts.minute_inc;  // [RQ2]
        end
        else
        begin
            tick_set = 1'b0;  // [RQ2]
        end
        // writing zero to the flag bit clears it
        tick_clr = wr_en && paddr[1:0] == 2'h0 && idx == IDX_FLAGS &&
                   !pwdata[FLG_TICK];  // [RQ14]
        if (tick_set)
        begin
            tick_flag_nxt = 1'b1;
        end
        else if (tick_clr)
        begin
            tick_flag_nxt = 1'b0;
        end
        else
        begin
            tick_flag_nxt = tick_flag_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_flag_r <= 1'b0;
        end
        else
        begin
            tick_flag_r <= tick_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // tick pulse generator, one 64 Hz period long
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_state_r <= RIO_PULSE_IDLE;
            pulse_cnt_r   <= '0;
        end
        else
        begin
            case (pulse_state_r)
                RIO_PULSE_IDLE:
                begin
                    if (tick_flag_nxt && !tick_flag_r && ctrl_r[CTL_PULSE])
                    begin
                        pulse_state_r <= RIO_PULSE_ON;  // [RQ3]
                        pulse_cnt_r   <= PULSE_CNT_W'(PULSE_LEN - 1);  // [RQ5]
                    end
                end
                RIO_PULSE_ON:
                begin
                    if (!tick_flag_nxt || pulse_cnt_r == '0)
                    begin
                        pulse_state_r <= RIO_PULSE_IDLE;  // [RQ6] [RQ5]
                        pulse_cnt_r   <= '0;
                    end
                    else
                    begin
                        pulse_cnt_r <= pulse_cnt_r - 1'b1;
                    end
                end
                default:
                begin
                    pulse_state_r <= RIO_PULSE_IDLE;
                    pulse_cnt_r   <= '0;
                end
            endcase
        end
    end

    // pulse in pulse mode, else level until the flag is cleared
    assign tick_req = ctrl_r[CTL_PULSE] ? (pulse_state_r == RIO_PULSE_ON)  // [RQ3]
                                        : tick_flag_r;  // [RQ4]

    assign req_a = route(mask_a_lo_r, mask_a_hi_r, ctrl_r, tick_req, flags);
    assign req_b = route(mask_b_lo_r, mask_b_hi_r, ctrl_r, tick_req, flags);

    // ------------------------------------------------------------
    // open-drain pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_a_oe_r <= 1'b0;
            irq_b_oe_r <= 1'b0;
            irq_a_o_r  <= 1'b0;
            irq_b_o_r  <= 1'b0;
        end
        else
        begin
            // drive low only while a request stands, else release
            irq_a_oe_r <= req_a;  // [RQ20] [RQ22] [RQ15]
            irq_b_oe_r <= req_b;  // [RQ20] [RQ22] [RQ15]
            irq_a_o_r  <= 1'b0;
            irq_b_o_r  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb read path and answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped(idx, paddr[1:0]);
            prdata_r  <= '0;
            if (setup && !pwrite && paddr[1:0] == 2'h0)
            begin
                case (idx)
                    IDX_MASK_A_LO: prdata_r <= {26'h0, mask_a_lo_r};  // [RQ19]
                    IDX_MASK_A_HI: prdata_r <= {28'h0, mask_a_hi_r};  // [RQ19]
                    IDX_MASK_B_LO: prdata_r <= {26'h0, mask_b_lo_r};
                    IDX_MASK_B_HI: prdata_r <= {28'h0, mask_b_hi_r};
                    IDX_CTRL:      prdata_r <= {20'h0, ctrl_r};
                    IDX_FLAGS:
                    begin
                        // low battery bit is status only, never written
                        prdata_r <= {22'h0, flags.low_battery_flag,  // [RQ13]
                                     flags.switchover_flag, flags.stamp_flags,
                                     flags.alarm_flag, flags.watchdog_flag,
                                     pulse_state_r == RIO_PULSE_ON, tick_flag_r};
                    end
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    assign pready       = pready_r;
    assign prdata       = prdata_r;
    assign pslverr      = pslverr_r;
    assign irq_out_a_o  = irq_a_o_r;
    assign irq_out_a_oe = irq_a_oe_r;
    assign irq_out_b_o  = irq_b_o_r;
    assign irq_out_b_oe = irq_b_oe_r;

endmodule

// ### hw/rio_pkg.sv
/*
 * rio_pkg: constants, register map and carrier types of the
 * rtc interrupt output router.
 * assumes: apb with 32-bit data, one register per aligned word.
 */
package rio_pkg;

    // ------------------------------------------------------------
    // clocking and tick pulse timing
    // ------------------------------------------------------------
    localparam int unsigned PCLK_HZ       = 40_000_000;
    localparam int unsigned TICK_CLK_HZ   = 64;
    localparam int unsigned PULSE_CYCLES  = PCLK_HZ / TICK_CLK_HZ;
    localparam int          PULSE_CNT_W   = 20;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_MASK_A_LO  = 8'h31;
    localparam logic [7:0] IDX_MASK_A_HI  = 8'h32;
    localparam logic [7:0] IDX_MASK_B_LO  = 8'h33;
    localparam logic [7:0] IDX_MASK_B_HI  = 8'h34;
    localparam logic [7:0] IDX_CTRL       = 8'h40;
    localparam logic [7:0] IDX_FLAGS      = 8'h41;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam logic [5:0] MASK_LO_RST    = 6'h3f;
    localparam logic [3:0] MASK_HI_RST    = 4'hf;
    localparam int         MLO_LONG       = 5;
    localparam int         MLO_SHORT      = 4;
    localparam int         MLO_WDOG       = 3;
    localparam int         MLO_ALARM      = 2;
    localparam int         MLO_SWITCH     = 1;
    localparam int         MLO_LOWBAT     = 0;
    // control register bits
    localparam int         CTL_LONG       = 0;
    localparam int         CTL_SHORT      = 1;
    localparam int         CTL_PULSE      = 2;
    localparam int         CTL_WDOG       = 3;
    localparam int         CTL_ALARM      = 4;
    localparam int         CTL_SWITCH     = 5;
    localparam int         CTL_LOWBAT     = 6;
    localparam int         CTL_STAMP      = 8;
    localparam logic [11:0] CTRL_RST      = 12'h000;
    // flag register bits
    localparam int         FLG_TICK       = 0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       watchdog_flag;
        logic       alarm_flag;
        logic [3:0] stamp_flags;
        logic       switchover_flag;
        logic       low_battery_flag;
    } rio_flags_t;

    typedef struct packed {
        logic       minute_inc;
        logic       second_inc;
    } rio_count_t;

    typedef enum logic [1:0] {
        RIO_PULSE_IDLE,
        RIO_PULSE_ON
    } rio_pulse_t;

endpackage

// ### sim/rio_chk.sv
/* rio_chk: port assertions for rio_top.
   assumes: bound into rio_top; one clock, async low reset. */
`timescale 1ns/1ps
module rio_chk
    import rio_pkg::*;
#(parameter int unsigned PULSE_LEN = 8)
(
    // clock, reset, apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // sources and outputs
    input wire rio_pkg::rio_count_t counts,
    input wire rio_pkg::rio_flags_t flags,
    input wire logic        irq_out_a_o,
    input wire logic        irq_out_a_oe,
    input wire logic        irq_out_b_o,
    input wire logic        irq_out_b_oe
);
    logic [11:0] ctl;
    logic [5:0]  la;
    logic [5:0]  lb;
    logic [3:0]  ha;
    logic [3:0]  hb;
    logic [7:0]  run;
    wire logic   wr = psel & penable & pready & pwrite;

    function automatic logic [11:0] ad(logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction
    function automatic logic rq(logic [5:0] l, logic [3:0] h);
        return (ctl[CTL_WDOG] & flags.watchdog_flag & ~l[MLO_WDOG])
            | (ctl[CTL_ALARM] & flags.alarm_flag & ~l[MLO_ALARM])
            | (ctl[CTL_SWITCH] & flags.switchover_flag & ~l[MLO_SWITCH])
            | (ctl[CTL_LOWBAT] & flags.low_battery_flag & ~l[MLO_LOWBAT])
            | (|(ctl[11:8] & flags.stamp_flags & ~h));
    endfunction
    function automatic logic tr(logic [5:0] l);
        return (ctl[CTL_LONG] & ~l[MLO_LONG]) | (ctl[CTL_SHORT] & ~l[MLO_SHORT]);
    endfunction

    // ----------------------------------------
    // register shadow and pulse length count
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl <= CTRL_RST;
            la  <= MASK_LO_RST;
            lb  <= MASK_LO_RST;
            ha  <= MASK_HI_RST;
            hb  <= MASK_HI_RST;
        end
        else if (wr)
        begin
            case (paddr)
                ad(IDX_CTRL):      ctl <= pwdata[11:0];
                ad(IDX_MASK_A_LO): la <= pwdata[5:0];
                ad(IDX_MASK_A_HI): ha <= pwdata[3:0];
                ad(IDX_MASK_B_LO): lb <= pwdata[5:0];
                ad(IDX_MASK_B_HI): hb <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run <= '0;
        else if (irq_out_a_oe && !rq(la, ha))
            run <= (run == 8'hff) ? run : run + 8'h1;
        else
            run <= '0;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_slot: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_misalign_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    a_reset_quiet: assert property ($rose(presetn) |-> (!irq_out_a_oe && !irq_out_b_oe) [*3])
        else $error("output driven after reset");
    a_drain_only: assert property (!irq_out_a_o && !irq_out_b_o)
        else $error("open drain data not low");
    a_a_asserts: assert property (rq(la, ha) |=> irq_out_a_oe)
        else $error("output a not asserted");
    a_b_asserts: assert property (rq(lb, hb) |=> irq_out_b_oe)
        else $error("output b not asserted");
    a_a_releases: assert property (!rq(la, ha) && !tr(la) |=> !irq_out_a_oe)
        else $error("output a not released");
    a_pulse_bounded: assert property (ctl[CTL_PULSE] |-> run <= PULSE_LEN)
        else $error("tick pulse too long");
    a_tick_rise: assert property (counts.second_inc && ctl[CTL_SHORT] && !la[MLO_SHORT]
        |=> ##1 irq_out_a_oe)
        else $error("tick did not reach output a");
    a_clear_drops: assert property (wr && paddr == ad(IDX_FLAGS) && !pwdata[0] && !rq(la, ha)
        && counts == '0 |=> ##1 !irq_out_a_oe)
        else $error("tick clear did not release output a");

    c_pulse: cover property (ctl[CTL_PULSE] && $fell(irq_out_a_oe));
    c_err: cover property (pslverr);
    c_b: cover property (irq_out_b_oe);
endmodule

bind rio_top rio_chk #(.PULSE_LEN(PULSE_LEN)) rio_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .counts(counts), .flags(flags), .irq_out_a_o(irq_out_a_o),
    .irq_out_a_oe(irq_out_a_oe), .irq_out_b_o(irq_out_b_o), .irq_out_b_oe(irq_out_b_oe));

// ### sim/rio_host_pin.sv
/* rio_host_pin: host interrupt inputs with pull-ups.
   assumes: oe high means the router pulls the pin down. */
`timescale 1ns/1ps
module rio_host_pin
(
    // router drive
    input wire logic oe_a,
    input wire logic o_a,
    input wire logic oe_b,
    input wire logic o_b,
    // levels seen by the host
    output logic     pin_a,
    output logic     pin_b
);
    // released pin floats up to the pull-up
    assign pin_a = oe_a ? o_a : 1'b1;
    assign pin_b = oe_b ? o_b : 1'b1;
endmodule

// ### sim/tb_top.sv
/* tb_top: apb-driven self-checking bench for rio_top.
   assumes: rio_host_pin as pull-up host, rio_chk bound. */
`timescale 1ns/1ps
module tb_top;
    import rio_pkg::*;
    localparam int unsigned PL = 8;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    rio_count_t  counts;
    rio_flags_t  flags;
    logic        oa, oea, ob, oeb, pin_a, pin_b;
    logic [9:0]  m;
    logic [1:0]  lo = 2'h0;
    int          fails, n_compared, cyc, n;
    int          fb[8] = '{7, 6, 1, 0, 5, 4, 3, 2};
    int          eb[8] = '{3, 4, 5, 6, 11, 10, 9, 8};
    int          mb[8] = '{3, 2, 1, 0, 9, 8, 7, 6};

    rio_top #(.PULSE_LEN(PL)) rio_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .counts(counts), .flags(flags), .irq_out_a_o(oa), .irq_out_a_oe(oea),
        .irq_out_b_o(ob), .irq_out_b_oe(oeb));
    rio_host_pin rio_host_pin_i (.oe_a(oea), .o_a(oa), .oe_b(oeb), .o_b(ob),
        .pin_a(pin_a), .pin_b(pin_b));

    always #12.5 pclk = ~pclk;

    // ----------------------------------------
    // bus, compare and closing tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] wd,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, lo};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] wd);
        logic [31:0] x;
        apb(1'b1, i, wd, x);
    endtask
    task automatic rd(input logic [7:0] i, output logic [31:0] q);
        apb(1'b0, i, 32'h0, q);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic pin(input logic ea, input logic eb2);
        repeat (3) @(posedge pclk);
        #1;
        check({30'h0, pin_b, pin_a}, {30'h0, eb2, ea});
    endtask
    task automatic tick(input logic [1:0] c, input logic e);
        counts <= rio_count_t'(c);
        @(posedge pclk);
        counts <= '0;
        repeat (20) @(posedge pclk);
        pin(!e, 1'b1);
        rd(IDX_FLAGS, d);
        check({31'h0, d[FLG_TICK]}, {31'h0, e});
        wr(IDX_FLAGS, 32'h0);
        pin(1'b1, 1'b1);
    endtask
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            finish_test();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        counts = '0;
        flags = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wr(IDX_CTRL, 32'hf78);
        flags <= rio_flags_t'(8'hff);
        pin(1'b1, 1'b1);
        flags <= '0;
        for (int i = 0; i < 4; i++)
        begin
            rd(IDX_MASK_A_LO + 8'(i), d);
            check(d, i[0] ? 32'hf : 32'h3f);
            wr(IDX_MASK_A_LO + 8'(i), 32'hffffffff);
            rd(IDX_MASK_A_LO + 8'(i), d);
            check(d, i[0] ? 32'hf : 32'h3f);
            wr(IDX_MASK_A_LO + 8'(i), 32'h0);
            rd(IDX_MASK_A_LO + 8'(i), d);
            check(d, 32'h0);
        end
        rd(8'h50, d);
        check({d[30:0], serr}, 32'h1);
        // misaligned word: refused, write ignored
        lo = 2'h2;
        wr(IDX_MASK_A_LO, 32'h3f);
        check({31'h0, serr}, 32'h1);
        rd(IDX_MASK_A_LO, d);
        check({d[30:0], serr}, 32'h1);
        lo = 2'h0;
        rd(IDX_MASK_A_LO, d);
        check(d, 32'h0);
        wr(IDX_MASK_B_LO, 32'h3f);
        wr(IDX_MASK_B_HI, 32'hf);
        for (int i = 0; i < 8; i++)
        begin
            m = ~(10'h1 << mb[i]);
            wr(IDX_MASK_A_LO, {26'h0, m[5:0]});
            wr(IDX_MASK_A_HI, {28'h0, m[9:6]});
            flags <= rio_flags_t'(8'h1 << fb[i]);
            pin(1'b0, 1'b1);
            wr(IDX_CTRL, 32'hf78 & ~(32'h1 << eb[i]));
            pin(1'b1, 1'b1);
            wr(IDX_CTRL, 32'hf78);
            pin(1'b0, 1'b1);
            flags <= '0;
            pin(1'b1, 1'b1);
        end
        wr(IDX_MASK_A_LO, 32'h3f);
        wr(IDX_MASK_A_HI, 32'hf);
        wr(IDX_MASK_B_LO, 32'h3e);
        flags <= rio_flags_t'(8'h01);
        pin(1'b1, 1'b0);
        wr(IDX_FLAGS, 32'h0);
        rd(IDX_FLAGS, d);
        check({31'h0, d[9]}, 32'h1);
        flags <= '0;
        wr(IDX_MASK_A_LO, 32'h0f);
        for (int k = 0; k < 4; k++)
        begin
            wr(IDX_CTRL, 32'(k));
            tick(2'b10, k == 1);
            tick(2'b01, k >= 2);
        end
        wr(IDX_CTRL, 32'h6);
        counts <= rio_count_t'(2'b01);
        @(posedge pclk);
        counts <= '0;
        n = 0;
        repeat (40)
        begin
            @(posedge pclk);
            #1;
            n += int'(!pin_a);
        end
        check(32'(n), 32'(PL));
        wr(IDX_FLAGS, 32'h0);
        counts <= rio_count_t'(2'b01);
        @(posedge pclk);
        counts <= '0;
        repeat (2) @(posedge pclk);
        wr(IDX_FLAGS, 32'h0);
        n = 0;
        repeat (20)
        begin
            @(posedge pclk);
            #1;
            n += int'(!pin_a);
        end
        check({31'h0, n < 2}, 32'h1);
        finish_test();
    end
endmodule
